/* File: rtl/ssp_pkg.sv */
// Shared constants and types for the serial shadow-register port.
// Assumes a 16-bit instruction frame clocked by the host's shift clock.
package ssp_pkg;

    // ------------------------------------------------------------------
    // Frame format
    // ------------------------------------------------------------------
    localparam int         INSTR_BITS = 16;       // Instruction length.
    localparam int         ADDR_BITS  = 13;       // Address field width.
    localparam int         RW_BIT     = 15;       // Read when set.
    localparam int         WL_HI      = 14;       // word_length_bit_high.
    localparam int         WL_LO      = 13;       // word_length_bit_low.
    localparam logic [1:0] WL_STREAM  = 2'h3;     // Streaming code.

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [12:0] ADDR_CFG        = 13'h0000; // Port config.
    localparam logic [12:0] ADDR_ID         = 13'h0001; // Chip identity.
    localparam logic [12:0] ADDR_GRADE      = 13'h0002; // Chip grade.
    localparam logic [12:0] ADDR_IDX2       = 13'h0004; // Channels E-H.
    localparam logic [12:0] ADDR_IDX1       = 13'h0005; // Channels A-D.
    localparam logic [12:0] ADDR_FUNC_FIRST = 13'h0008; // First function.
    localparam logic [12:0] ADDR_FUNC_LAST  = 13'h002D; // Last function.
    localparam logic [12:0] ADDR_CLK        = 13'h0009; // Clock register.
    localparam logic [12:0] ADDR_XFER       = 13'h00FF; // transfer_commit.
    localparam int          FUNC_COUNT      = 38;       // 0x08 to 0x2D.
    localparam int          CLK_INDEX       = 1;        // 0x09 - 0x08.

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         CFG_LSB_HI  = 6;       // Mirrored LSB-first bits.
    localparam int         CFG_LSB_LO  = 1;
    localparam int         CFG_SRST_HI = 5;       // Mirrored soft reset bits.
    localparam int         CFG_SRST_LO = 2;
    localparam int         XFER_BIT    = 0;       // transfer_commit_bit.
    localparam int         DCS_BIT     = 0;       // Stabilizer enable bit.
    localparam logic [7:0] CFG_FIXED   = 8'h18;   // Constant ones at 0x00.
    localparam logic [7:0] CLK_RESET   = 8'h01;   // Clock register reset.
    localparam logic [7:0] FUNC_RESET  = 8'h00;   // Other function resets.
    localparam logic [3:0] IDX2_RESET  = 4'hF;    // Channels E-H on.
    localparam logic [5:0] IDX1_RESET  = 6'h0F;   // Channels A-D on.

    // ------------------------------------------------------------------
    // Turnaround timing of the data pin
    // ------------------------------------------------------------------
    localparam int T_CLK_NS      = 20;            // System clock period.
    localparam int T_EN_SDIO_NS  = 10;            // Least input-to-output.
    localparam int T_DIS_SDIO_NS = 10;            // Least output-to-input.
    localparam int EN_SDIO_CYC   = (T_EN_SDIO_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int DIS_SDIO_CYC  = (T_DIS_SDIO_NS + T_CLK_NS - 1) / T_CLK_NS;

    // Function register bank, one byte per address.
    typedef logic [FUNC_COUNT-1:0][7:0] ssp_func_t;

    // Serial frame phases.
    typedef enum logic [1:0] {
        SSP_INSTR,
        SSP_DATA,
        SSP_DONE
    } ssp_phase_t;

    // Reset image of the function bank.
    function automatic ssp_func_t ssp_func_reset();
        ssp_func_t v;
        v = '{default: FUNC_RESET};
        v[CLK_INDEX] = CLK_RESET;
        return v;
    endfunction : ssp_func_reset

endpackage : ssp_pkg

/* File: rtl/ssp_port.sv */
// Serial configuration port with double-buffered register bank.
// Assumes the host drives sclk and port_select_n and obeys serial timing;
// the board resolves the data pin from sdio_out and sdio_oe.
//
// Notes on behaviour
// - Shift clock and select are inputs only.
// - Data pin driven only during readback phases.
// - Pin turns to output after a falling edge.
// - Pin released to input around rising edge; the driver releases it on the next falling edge, or at once when select rises.
// - Select high at reset disables port, straps pins.
// - Config, index/transfer and function address sections.
// - Most registers shadowed until a commit.
// - Writing one to transfer copies shadows live.
// - Clock register resets to 0x01, bit0 stabilizer.
// - Stabilizer off only after zero plus commit.
// - Any reset reloads documented default values.
// - Sixteen-bit instruction sets direction and length.
// - Both length bits set means stream.
// - Select rising mid-byte restarts the frame.
// - MSB first until configuration selects LSB.
module ssp_port #(
    parameter logic [7:0] CHIP_ID_VALUE = 8'h5A,  // Arbitrary identity.
    parameter logic [7:0] GRADE_VALUE   = 8'h00   // Grade readback.
) (
    // System clock domain.
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Serial link pins.
    input  wire logic                          sclk,
    input  wire logic                          port_select_n,
    input  wire logic                          sdio_in,
    output logic                               sdio_out,
    output logic                               sdio_oe,
    // Strap status and secondary pin functions.
    output logic                               port_disabled,
    output logic                               secondary_sclk_level,
    output logic                               secondary_sdio_level,
    // Live configuration.
    output logic                               duty_stabilizer_en,
    output logic                               lsb_first_mode,
    output logic [7:0]                         data_channel_select,
    output logic [1:0]                         clock_channel_select,
    output logic [ssp_pkg::FUNC_COUNT*8-1:0]   func_active
);
    import ssp_pkg::*;

    // Refuse a function bank that does not match its address range.
    if (int'(ADDR_FUNC_LAST - ADDR_FUNC_FIRST) + 1 != FUNC_COUNT) begin : g_chk
        $error("Function bank size does not match its address range.");
    end

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    // Frame sequencer, cleared whenever the select is high.
    typedef struct packed {
        ssp_phase_t            phase;     // Instruction, data or done.
        logic [3:0]            bitcnt;    // Bit within word.
        logic [15:0]           sr;        // Input shift register.
        logic                  rd;        // Frame is a readback.
        logic [1:0]            wl;        // Word length code.
        logic [ADDR_BITS-1:0]  addr;      // Current byte address.
        logic [1:0]            nbytes;    // Bytes already moved.
    } ssp_frame_t;

    // Register bank on the shift clock.
    typedef struct packed {
        logic                  dis_s1;    // Disable sync, first stage.
        logic                  dis_s2;    // Disable sync, second stage.
        logic                  lsb_first; // Bit order of the link.
        logic [3:0]            idx2;      // Channels E-H select.
        logic [5:0]            idx1;      // Clocks and channels A-D.
        ssp_func_t             shadow;    // Written values.
        ssp_func_t             active;    // Values in effect.
        logic                  upd_tgl;   // Flips on every live change.
    } ssp_regs_t;

    // Data pin driver on the falling shift clock edge.
    typedef struct packed {
        logic                  out;       // Pin value.
        logic                  oe;        // Pin enable.
    } ssp_drv_t;

    // System clock side.
    typedef struct packed {
        logic                  cs_s1;     // Select sync stages.
        logic                  cs_s2;
        logic                  sck_s1;    // Shift clock level sync.
        logic                  sck_s2;
        logic                  sdo_s1;    // Data pin level sync.
        logic                  sdo_s2;
        logic                  tg_s1;     // Update toggle sync.
        logic                  tg_s2;
        logic                  tg_s3;     // Delayed copy for edge detect.
        logic [1:0]            strap_cnt; // Edges since reset release.
        logic                  disabled;  // Port strapped off.
        logic                  sec_sclk;  // Secondary function levels.
        logic                  sec_sdio;
        logic                  dcs_en;    // Stabilizer enable.
        logic                  lsb;       // Bit order copy.
        logic [7:0]            data_sel;  // Data channel select.
        logic [1:0]            clk_sel;   // Clock channel select.
        ssp_func_t             func;      // Function bank copy.
    } ssp_core_t;

    ssp_frame_t            f;             // Frame state.
    ssp_frame_t            next_f;        // Next frame state.
    ssp_regs_t             r;             // Register state.
    ssp_regs_t             next_r;        // Next register state.
    ssp_drv_t              d;             // Pin driver state.
    ssp_drv_t              next_d;        // Next pin driver state.
    ssp_core_t             c;             // System side state.
    ssp_core_t             next_c;        // Next system side state.
    logic                  frame_rst;     // Frame reset, select or rst.
    logic                  wr_stb;        // Data byte written this edge.
    logic [7:0]            wr_data;       // Byte being written.
    logic [7:0]            rd_byte;       // Byte at the current address.
    logic [15:0]           sr_in;         // Shift register with new bit.

    // ------------------------------------------------------------------
    // Readback multiplexer
    // ------------------------------------------------------------------
    // Decodes the three address sections; unmapped addresses read zero.
    always_comb begin
        logic [5:0] fi;
        fi = 6'(f.addr - ADDR_FUNC_FIRST);
        rd_byte = 8'h00;
        if (f.addr == ADDR_CFG) begin
            rd_byte = CFG_FIXED;
            rd_byte[CFG_LSB_HI] = r.lsb_first;
            rd_byte[CFG_LSB_LO] = r.lsb_first;
        end else if (f.addr == ADDR_ID) begin
            rd_byte = CHIP_ID_VALUE;
        end else if (f.addr == ADDR_GRADE) begin
            rd_byte = GRADE_VALUE;
        end else if (f.addr == ADDR_IDX2) begin
            rd_byte = {4'h0, r.idx2};
        end else if (f.addr == ADDR_IDX1) begin
            rd_byte = {2'h0, r.idx1};
        end else if (f.addr >= ADDR_FUNC_FIRST
                     && f.addr <= ADDR_FUNC_LAST) begin
            rd_byte = r.active[fi];
        end
    end

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    // Shift clock and select are only ever inputs; a high select holds
    // the whole sequencer in reset, so a partial byte is discarded.
    assign frame_rst = rst | port_select_n;

    // Shifts the instruction, then moves data bytes in either direction.
    always_comb begin
        next_f  = f;
        wr_stb  = 1'b0;
        wr_data = 8'h00;
        // New bit enters at the top in LSB-first order, else the bottom.
        sr_in = r.lsb_first ? {sdio_in, f.sr[15:1]}
                            : {f.sr[14:0], sdio_in};
        next_f.sr = sr_in;
        unique case (f.phase)
            SSP_INSTR: begin
                if (f.bitcnt == 4'(INSTR_BITS - 1)) begin
                    next_f.rd     = sr_in[RW_BIT];
                    next_f.wl     = sr_in[WL_HI:WL_LO];
                    next_f.addr   = sr_in[ADDR_BITS-1:0];
                    next_f.nbytes = 2'h0;
                    next_f.bitcnt = 4'h0;
                    next_f.phase  = SSP_DATA;
                end else begin
                    next_f.bitcnt = f.bitcnt + 4'h1;
                end
            end
            SSP_DATA: begin
                if (f.bitcnt == 4'h7) begin
                    next_f.bitcnt = 4'h0;
                    // A write lands at the last rising edge of its byte.
                    wr_stb  = ~f.rd & ~r.dis_s2;
                    wr_data = r.lsb_first ? sr_in[15:8] : sr_in[7:0];
                    // Address climbs in LSB-first order, falls otherwise.
                    next_f.addr = r.lsb_first ? f.addr + 13'h0001
                                              : f.addr - 13'h0001;
                    next_f.nbytes = f.nbytes + 2'h1;
                    // Streaming runs until the select rises.
                    if (f.wl != WL_STREAM && f.nbytes == f.wl) begin
                        next_f.phase = SSP_DONE;
                    end
                end else begin
                    next_f.bitcnt = f.bitcnt + 4'h1;
                end
            end
            SSP_DONE: begin
                // Extra clocks after the last byte are ignored.
                next_f.sr = f.sr;
            end
        endcase
    end

    // Frame register on the rising shift clock edge.
    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            f <= '{phase: SSP_INSTR, default: '0};
        end else begin
            f <= next_f;
        end
    end

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------
    // Applies written bytes; shadowed addresses wait for a commit.
    always_comb begin
        logic [5:0] wi;
        wi = 6'(f.addr - ADDR_FUNC_FIRST);
        next_r = r;
        // The strap decision crosses from the system clock.
        next_r.dis_s1 = c.disabled;
        next_r.dis_s2 = r.dis_s1;
        if (wr_stb) begin
            if (f.addr == ADDR_CFG) begin
                if (wr_data[CFG_SRST_HI] | wr_data[CFG_SRST_LO]) begin
                    // Soft reset restores defaults and clears itself.
                    next_r.lsb_first = 1'b0;
                    next_r.idx2      = IDX2_RESET;
                    next_r.idx1      = IDX1_RESET;
                    next_r.shadow    = ssp_func_reset();
                    next_r.active    = ssp_func_reset();
                end else begin
                    // Either mirrored bit selects LSB-first order.
                    next_r.lsb_first = wr_data[CFG_LSB_HI]
                                     | wr_data[CFG_LSB_LO];
                end
                next_r.upd_tgl = ~r.upd_tgl;
            end else if (f.addr == ADDR_IDX2) begin
                next_r.idx2    = wr_data[3:0];
                next_r.upd_tgl = ~r.upd_tgl;
            end else if (f.addr == ADDR_IDX1) begin
                next_r.idx1    = wr_data[5:0];
                next_r.upd_tgl = ~r.upd_tgl;
            end else if (f.addr == ADDR_XFER) begin
                // The commit copies at once, so the bit never reads set.
                if (wr_data[XFER_BIT]) begin
                    next_r.active  = r.shadow;
                    next_r.upd_tgl = ~r.upd_tgl;
                end
            end else if (f.addr >= ADDR_FUNC_FIRST
                         && f.addr <= ADDR_FUNC_LAST) begin
                next_r.shadow[wi] = wr_data;
            end
        end
    end

    // Register bank flip-flops; defaults on the system reset.
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            r <= '{idx2:   IDX2_RESET,
                   idx1:   IDX1_RESET,
                   shadow: ssp_func_reset(),
                   active: ssp_func_reset(),
                   default: '0};
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Data pin driver
    // ------------------------------------------------------------------
    // Drives on falling edges so the host samples on rising ones. The
    // half period of the shift clock covers the pin turnaround time.
    always_comb begin
        next_d.oe  = (f.phase == SSP_DATA) & f.rd & ~r.dis_s2;
        next_d.out = r.lsb_first ? rd_byte[f.bitcnt[2:0]]
                                 : rd_byte[3'h7 - f.bitcnt[2:0]];
        if (!next_d.oe) begin
            next_d.out = 1'b0;
        end
    end

    // Driver flip-flops; a rising select releases the pin at once.
    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            d <= '0;
        end else begin
            d <= next_d;
        end
    end

    assign sdio_out = d.out;
    assign sdio_oe  = d.oe;

    // ------------------------------------------------------------------
    // System clock side
    // ------------------------------------------------------------------
    // Catches the strap after release and copies live words on a toggle.
    always_comb begin
        next_c        = c;
        next_c.cs_s1  = port_select_n;
        next_c.cs_s2  = c.cs_s1;
        next_c.sck_s1 = sclk;
        next_c.sck_s2 = c.sck_s1;
        next_c.sdo_s1 = sdio_in;
        next_c.sdo_s2 = c.sdo_s1;
        next_c.tg_s1  = r.upd_tgl;
        next_c.tg_s2  = c.tg_s1;
        next_c.tg_s3  = c.tg_s2;
        // Two edges flush the synchroniser before the strap is taken.
        if (c.strap_cnt != 2'h3) begin
            next_c.strap_cnt = c.strap_cnt + 2'h1;
            if (c.strap_cnt == 2'h2) begin
                next_c.disabled = c.cs_s2;
            end
        end
        // A strapped port hands its pin levels to secondary functions.
        next_c.sec_sclk = c.disabled & c.sck_s2;
        next_c.sec_sdio = c.disabled & c.sdo_s2;
        // Words from the shift domain are stable around each toggle.
        if (c.tg_s2 != c.tg_s3) begin
            next_c.dcs_en   = r.active[CLK_INDEX][DCS_BIT];
            next_c.lsb      = r.lsb_first;
            next_c.data_sel = {r.idx2, r.idx1[3:0]};
            next_c.clk_sel  = r.idx1[5:4];
            next_c.func     = r.active;
        end
    end

    // System side flip-flops.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c <= '{dcs_en:   CLK_RESET[DCS_BIT],
                   data_sel: {IDX2_RESET, IDX1_RESET[3:0]},
                   clk_sel:  IDX1_RESET[5:4],
                   func:     ssp_func_reset(),
                   default:  '0};
        end else begin
            c <= next_c;
        end
    end

    assign port_disabled        = c.disabled;
    assign secondary_sclk_level = c.sec_sclk;
    assign secondary_sdio_level = c.sec_sdio;
    assign duty_stabilizer_en   = c.dcs_en;
    assign lsb_first_mode       = c.lsb;
    assign data_channel_select  = c.data_sel;
    assign clock_channel_select = c.clk_sel;
    assign func_active          = c.func;

endmodule : ssp_port

/* File: sim/ssp_host.sv */
// Host controller model: shift clock, select and the shared data wire.
// Assumes the device drives the wire only while sdio_oe is high.
module ssp_host (
    // Pins towards the device.
    output logic      sclk,
    output logic      port_select_n,
    output logic      sdio_in,
    input  wire logic sdio_out,
    input  wire logic sdio_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic drv; // Host's own drive; toggles once released, as no pull exists.
    assign sdio_in = sdio_oe ? sdio_out : drv;
    initial begin
        sclk = 1'b0;
        port_select_n = 1'b1;
        drv = 1'b0;
    end
    // Sets the select level, used around reset for the strap.
    task automatic hold_sel(input logic v);
        port_select_n = v;
    endtask : hold_sel
    // One frame: instruction then n data bits; the clock stops outside.
    task automatic frame(input logic [15:0] ins, input logic [15:0] wd,
                         input int n, input logic lsb,
                         output logic [15:0] rd);
        logic [31:0] w;
        int          j;
        w = {ins, wd};
        rd = '0;
        port_select_n = 1'b1;
        #6 port_select_n = 1'b0;
        for (int i = 0; i < 16 + n; i++) begin
            j = lsb ? (i < 16 ? i + 16 : 8 + (i - 16) % 8) : 31 - i;
            #3 sclk = 1'b0;
            drv = (i < 16 || !ins[15]) ? w[j] : ~drv;
            #3 sclk = 1'b1;
            rd = {rd[14:0], sdio_in};
        end
        #3 sclk = 1'b0;
        #3 port_select_n = 1'b1;
    endtask : frame
endmodule : ssp_host

/* File: sim/ssp_port_assertions.sv */
// Concurrent checks on the serial port pins and the live outputs.
// Bound to ssp_port; it sees that module's ports and nothing else.
module ssp_port_assertions (
    // Clocks, resets and pins.
    input wire logic       clk, rst, sclk, port_select_n, sdio_in,
    input wire logic       sdio_out, sdio_oe, port_disabled,
    input wire logic       secondary_sclk_level, secondary_sdio_level,
    // Live configuration.
    input wire logic       duty_stabilizer_en, lsb_first_mode,
    input wire logic [7:0] data_channel_select,
    input wire logic [1:0] clock_channel_select
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] n;  // Rising shift edges seen in this frame.
    logic [2:0] hd; // First three instruction bits, direction first in MSB-first order.
    logic [2:0] k;  // System clock edges since reset, saturating.
    // Frame tracker; select high clears it, as it does the frame logic.
    always_ff @(posedge sclk or posedge port_select_n) begin
        if (port_select_n) begin
            n  <= '0;
            hd <= '0;
        end else begin
            n  <= (n == 5'h1F) ? n : n + 5'h01;
            hd <= (n < 5'h03) ? {hd[1:0], sdio_in} : hd;
        end
    end
    // Strap window counter.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) k <= '0;
        else k <= (k == 3'h7) ? k : k + 3'h1;
    end
    // One-byte read instruction, once its turnaround edge has passed.
    sequence s_rd_instr;
        n == 5'h11 && hd == 3'b100 && !lsb_first_mode;
    endsequence
    property p_sel_off;
        @(posedge clk) disable iff (rst) port_select_n |-> !sdio_oe;
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("oe with select high");
    property p_dis_off;
        @(posedge clk) disable iff (rst) port_disabled |-> !sdio_oe;
    endproperty
    a_dis_off: assert property (p_dis_off) else $error("oe when disabled");
    property p_out_idle;
        @(posedge clk) disable iff (rst) !sdio_oe |-> !sdio_out;
    endproperty
    a_out_idle: assert property (p_out_idle) else $error("idle data");
    property p_sec_zero;
        @(posedge clk) disable iff (rst) !port_disabled || k == 3'h7
            |-> secondary_sclk_level == (port_disabled && $past(sclk, 3))
            && secondary_sdio_level == (port_disabled && $past(sdio_in, 3));
    endproperty
    a_sec_zero: assert property (p_sec_zero) else $error("secondary");
    property p_strap_hold;
        @(posedge clk) disable iff (rst) k == 3'h7 |-> $stable(port_disabled);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap");
    property p_defaults;
        @(posedge clk) disable iff (rst) $past(rst) |-> duty_stabilizer_en
            && !lsb_first_mode && data_channel_select == 8'hFF
            && clock_channel_select == 2'h0;
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults");
    property p_oe_late;
        @(negedge sclk) disable iff (port_select_n) n <= 5'h10 |-> !sdio_oe;
    endproperty
    a_oe_late: assert property (p_oe_late) else $error("early oe");
    property p_oe_read;
        @(negedge sclk) disable iff (port_select_n) s_rd_instr |-> sdio_oe[*8];
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("read oe");
    property p_oe_write;
        @(negedge sclk) disable iff (port_select_n)
            n > 5'h10 && !hd[2] && !lsb_first_mode |-> !sdio_oe;
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("write oe");
    property p_dis_frozen;
        @(posedge clk) disable iff (rst)
            port_disabled && k == 3'h7 |-> $stable(data_channel_select);
    endproperty
    a_dis_frozen: assert property (p_dis_frozen) else $error("frozen");
endmodule : ssp_port_assertions

bind ssp_port ssp_port_assertions u_chk (.clk, .rst, .sclk, .port_select_n,
    .sdio_in, .sdio_out, .sdio_oe, .port_disabled, .secondary_sclk_level,
    .secondary_sdio_level, .duty_stabilizer_en, .lsb_first_mode,
    .data_channel_select, .clock_channel_select);

/* File: sim/ssp_port_bench.sv */
// Self-checking bench for ssp_port driven through the host model.
// Assumes ssp_pkg and the bound checker are compiled beforehand.
module ssp_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ssp_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       sclk, port_select_n, sdio_in, sdio_out, sdio_oe;
    logic       port_disabled, secondary_sclk_level, secondary_sdio_level;
    logic       duty_stabilizer_en, lsb_first_mode;
    logic [7:0] data_channel_select;
    logic [1:0] clock_channel_select;
    logic [FUNC_COUNT*8-1:0] func_active;
    logic [15:0] rd;
    int         num_errors = 0;
    int         compares = 0;
    int         cycles = 0;
    always #10 clk = ~clk;
    // Identity value below is arbitrary.
    ssp_port #(.CHIP_ID_VALUE(8'hA7)) dut (.clk, .rst, .sclk, .port_select_n,
        .sdio_in, .sdio_out, .sdio_oe, .port_disabled, .secondary_sclk_level,
        .secondary_sdio_level, .duty_stabilizer_en, .lsb_first_mode,
        .data_channel_select, .clock_channel_select, .func_active);
    ssp_host host (.sclk, .port_select_n, .sdio_in, .sdio_out, .sdio_oe);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // Frame, then six clocks so the live outputs have crossed over.
    task automatic go(input logic [15:0] ins, input logic [15:0] wd,
                      input int n, input logic lsb = 1'b0);
        host.frame(ins, wd, n, lsb, rd);
        repeat (6) @(posedge clk);
        #1.5;
    endtask : go
    // Reset with the select pin held at the given strap level.
    task automatic do_reset(input logic sel);
        host.hold_sel(sel);
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #1.5 rst = 1'b0;
        repeat (6) @(posedge clk);
        #1.5;
    endtask : do_reset
    // Hang guard.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        do_reset(1'b1);
        chk(port_disabled, 1'b1);
        go(16'h0005, 16'h0000, 8);
        chk(data_channel_select, 8'hFF);
        do_reset(1'b0);
        chk(port_disabled, 1'b0);
        chk({duty_stabilizer_en, func_active[15:8]}, {1'b1, CLK_RESET});
        chk({lsb_first_mode, clock_channel_select}, 3'h0);
        go(16'h8001, 16'h0000, 8);
        chk(rd[7:0], 8'hA7);
        go(16'h8000, 16'h0000, 8);
        chk(rd[7:0], CFG_FIXED);
        go(16'h8003, 16'h0000, 8);
        chk(rd[7:0], 8'h00);
        go({3'h0, ADDR_CLK}, 16'h0000, 8);
        chk(duty_stabilizer_en, 1'b1);
        go({3'h4, ADDR_CLK}, 16'h0000, 8);
        chk(rd[7:0], 8'h01);
        go({3'h0, ADDR_XFER}, 16'h0100, 8);
        chk({duty_stabilizer_en, func_active[15:8]}, 9'h000);
        go({3'h4, ADDR_XFER}, 16'h0000, 8);
        chk(rd[7:0], 8'h00);
        go({3'h0, ADDR_IDX2}, 16'h0300, 8);
        chk(data_channel_select, 8'h3F);
        go({3'h0, ADDR_IDX1}, 16'h0000, 4);
        chk(data_channel_select, 8'h3F);
        go(16'h6005, 16'h3A05, 16);
        chk({clock_channel_select, data_channel_select}, 10'h35A);
        go(16'hA005, 16'h0000, 16);
        chk(rd, 16'h3A05);
        go(16'hC006, 16'h0000, 24);
        chk(rd, 16'h3A05);
        go(16'h0000, 16'h4200, 8);
        chk(lsb_first_mode, 1'b1);
        go(16'h0005, 16'h0100, 8, 1'b1);
        chk(data_channel_select[3:0], 4'h1);
        go(16'h0000, 16'h2400, 8, 1'b1);
        chk({lsb_first_mode, duty_stabilizer_en}, 2'b01);
        report_and_stop();
    end
endmodule : ssp_port_bench
